//--- fdc_defines.svh
// Constants of the fault dispatch unit
`ifndef FDC_DEFINES_SVH
`define FDC_DEFINES_SVH
// ****************************************
// Control block word offsets, frame size and frame cap
// ****************************************
`define FDC_VEC_RING0  8'h32
`define FDC_VEC_RING1  8'h34
`define FDC_VEC_RING3  8'h38
`define FDC_VEC_PAGE   8'h3A
`define FDC_CS_FIRST   8'h3C
`define FDC_CS_NEXT    8'h3D
`define FDC_CS_LAST    8'h3E
`define FDC_CS_FRAMES  8'h3F
`define FDC_FRAME_WORDS 16'h0006
`define FDC_FRAME_CAP  4'h6
// ****************************************
// Fault numbers, codes, opcodes, entry argument offset and ring bits
// ****************************************
`define FDC_NUM_SEMA   4'h5
`define FDC_NUM_SEG    4'hC
`define FDC_NUM_PTR    4'hD
`define FDC_CODE_CALL  16'h8000
`define FDC_HALT_OP    16'h0000
`define FDC_HCALL_OP   16'h0705
`define FDC_ENT_NARGS  32'h0000_0004
`define FDC_RING_MSB   30
`define FDC_RING_LSB   29
// ****************************************
// Register map, fields and response codes
// ****************************************
`define FDC_REG_CTRL   8'h00
`define FDC_REG_CBLK   8'h04
`define FDC_REG_STATUS 8'h08
`define FDC_REG_PC     8'h0C
`define FDC_REG_ENTRY  8'h10
`define FDC_CTRL_EN    0
`define FDC_CTRL_RESUME 1
`define FDC_RESP_OKAY  2'h0
`define FDC_RESP_SLV   2'h2
`endif

//--- fdc_pkg.sv
// Types of the fault dispatch unit
package fdc_pkg;
  typedef enum logic [3:0] {
    FDC_IDLE     = 4'h0,
    FDC_RD_PTR   = 4'h1,
    FDC_WR_FRAME = 4'h3,
    FDC_WR_NEXT  = 4'h2,
    FDC_RD_VEC   = 4'h6,
    FDC_RD_ENT   = 4'h7,
    FDC_RD_ECB   = 4'h5,
    FDC_DISPATCH = 4'h4,
    FDC_HALTED   = 4'hC,
    FDC_POP_FLAG = 4'h8,
    FDC_POP_NEXT = 4'h9
  } fdc_state_e;
  typedef enum logic [1:0] {
    FDC_DEST_RING0 = 2'h0,
    FDC_DEST_RING1 = 2'h1,
    FDC_DEST_RING3 = 2'h2,
    FDC_DEST_PAGE  = 2'h3
  } fdc_dest_e;
  typedef struct packed {
    logic [3:0]  num;
    logic [1:0]  sub;
    fdc_dest_e   dest;
    logic [15:0] code;
    logic [31:0] pc;
    logic [15:0] keys;
    logic [31:0] addr;
  } fdc_fault_s;
endpackage

//--- fdc_dispatch.sv
// Fault dispatch unit with concealed stack and AXI4-Lite registers
`timescale 1ns/1ns
`include "fdc_defines.svh"
module fdc_dispatch
  import fdc_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_reset,
  input  wire logic        i_fault_valid,
  input  wire fdc_fault_s  i_fault,
  input  wire logic        i_pop_valid,
  input  wire logic [31:0] i_pop_flag_addr,
  output logic             o_ready,
  output logic             o_mem_req,
  output logic             o_mem_we,
  output logic [31:0]      o_mem_addr,
  output logic [15:0]      o_mem_wdata,
  input  wire logic        i_mem_ack,
  input  wire logic [15:0] i_mem_rdata,
  output logic             o_pc_load,
  output logic [31:0]      o_pc,
  output logic             o_int_block,
  output logic             o_dummy_args,
  output logic             o_mode64v,
  output logic             o_halt,
  input  wire logic [7:0]  i_awaddr,
  input  wire logic        i_awvalid,
  output logic             o_awready,
  input  wire logic [31:0] i_wdata,
  input  wire logic [3:0]  i_wstrb,
  input  wire logic        i_wvalid,
  output logic             o_wready,
  output logic [1:0]       o_bresp,
  output logic             o_bvalid,
  input  wire logic        i_bready,
  input  wire logic [7:0]  i_araddr,
  input  wire logic        i_arvalid,
  output logic             o_arready,
  output logic [31:0]      o_rdata,
  output logic [1:0]       o_rresp,
  output logic             o_rvalid,
  input  wire logic        i_rready
);
  // ****************************************
  // Helper functions
  // ****************************************
  function automatic logic [7:0] vec_loc(input fdc_dest_e d);
    case (d)
      FDC_DEST_RING0: vec_loc = `FDC_VEC_RING0;
      FDC_DEST_RING1: vec_loc = `FDC_VEC_RING1;
      FDC_DEST_RING3: vec_loc = `FDC_VEC_RING3;
      default:        vec_loc = `FDC_VEC_PAGE;
    endcase
  endfunction

  // Four words per entry, sixteen entries
  function automatic logic [15:0] type_off(input logic [3:0] n);
    type_off = {10'h000, n, 2'h0};
  endfunction

  function automatic logic [15:0] code_of(input fdc_fault_s f);
    if (f.num == `FDC_NUM_SEMA)
      code_of = {15'h0000, f.sub[0]};
    else if (f.num == `FDC_NUM_SEG)
      code_of = f.sub[0] ? 16'h0002 : 16'h0001;
    else if (f.num == `FDC_NUM_PTR && f.sub[0])
      code_of = `FDC_CODE_CALL;
    else
      code_of = f.code;
  endfunction

  function automatic logic [15:0] frame_word(input fdc_fault_s f,
                                             input logic [2:0] i);
    case (i)
      3'h0:    frame_word = f.pc[31:16];
      3'h1:    frame_word = f.pc[15:0];
      3'h2:    frame_word = f.keys;
      3'h3:    frame_word = code_of(f);
      3'h4:    frame_word = f.addr[31:16];
      default: frame_word = f.addr[15:0];
    endcase
  endfunction

  function automatic logic [15:0] adv(input logic [15:0] n,
                                      input logic [15:0] fst,
                                      input logic [15:0] lst);
    logic [15:0] s;
    s = n + `FDC_FRAME_WORDS;
    adv = (s > lst) ? fst : s;
  endfunction

  function automatic logic [15:0] back(input logic [15:0] n,
                                       input logic [15:0] fst,
                                       input logic [15:0] lst);
    back = (n == fst) ? lst : n - `FDC_FRAME_WORDS;
  endfunction

  // ****************************************
  // Dispatch sequencer
  // ****************************************
  fdc_state_e  st_reg,    st_next;
  logic [2:0]  idx_reg,   idx_next;
  fdc_fault_s  f_reg,     f_next;
  logic [15:0] first_reg, first_next;
  logic [15:0] nxt_reg,   nxt_next;
  logic [15:0] last_reg,  last_next;
  logic [31:0] vec_reg,   vec_next;
  logic [31:0] eblk_reg,  eblk_next;
  logic [31:0] flag_reg,  flag_next;
  logic [3:0]  depth_reg, depth_next;
  logic [7:0]  lost_reg,  lost_next;
  logic        dum_next,  pcl_next, blk_next, m64_next, rdy_next;
  logic        req_next,  we_next;
  logic [31:0] addr_next, pc_next, ent_addr;
  logic [15:0] wd_next;
  logic        en_reg,    resume_reg;
  logic [31:0] cblk_reg;

  assign ent_addr = {vec_reg[31:16],
                     vec_reg[15:0] + type_off(f_reg.num)};

  always_comb begin
    st_next = st_reg;
    idx_next = idx_reg;
    f_next = f_reg;
    first_next = first_reg;
    nxt_next = nxt_reg;
    last_next = last_reg;
    vec_next = vec_reg;
    eblk_next = eblk_reg;
    flag_next = flag_reg;
    depth_next = depth_reg;
    lost_next = lost_reg;
    dum_next = o_dummy_args;
    pc_next = o_pc;
    m64_next = o_mode64v;
    pcl_next = 1'b0;
    blk_next = 1'b0;
    case (st_reg)
      FDC_IDLE: begin
        // A new fault pre-empts a pending pop
        if (i_fault_valid && en_reg) begin
          f_next = i_fault;
          idx_next = 3'h0;
          st_next = FDC_RD_PTR;
        end else if (i_pop_valid) begin
          flag_next = i_pop_flag_addr;
          st_next = FDC_POP_FLAG;
        end
      end
      FDC_RD_PTR: if (i_mem_ack) begin
        case (idx_reg)
          3'h0:    first_next = i_mem_rdata;
          3'h1:    nxt_next = i_mem_rdata;
          default: last_next = i_mem_rdata;
        endcase
        idx_next = (idx_reg == 3'h2) ? 3'h0 : idx_reg + 3'h1;
        if (idx_reg == 3'h2)
          st_next = FDC_WR_FRAME;
      end
      FDC_WR_FRAME: if (i_mem_ack) begin
        idx_next = (idx_reg == 3'h5) ? 3'h0 : idx_reg + 3'h1;
        if (idx_reg == 3'h5)
          st_next = FDC_WR_NEXT;
      end
      FDC_WR_NEXT: if (i_mem_ack) begin
        nxt_next = adv(nxt_reg, first_reg, last_reg);
        if (depth_reg == `FDC_FRAME_CAP)
          lost_next = lost_reg + 8'h01;
        else
          depth_next = depth_reg + 4'h1;
        m64_next = 1'b1;
        st_next = FDC_RD_VEC;
      end
      FDC_RD_VEC: if (i_mem_ack) begin
        if (idx_reg == 3'h0) begin
          vec_next[31:16] = i_mem_rdata;
          idx_next = 3'h1;
        end else begin
          vec_next[15:0] = i_mem_rdata;
          idx_next = 3'h0;
          st_next = FDC_RD_ENT;
        end
      end
      FDC_RD_ENT: if (i_mem_ack) begin
        idx_next = idx_reg + 3'h1;
        if (idx_reg == 3'h0) begin
          dum_next = 1'b0;
          // Any other opcode is run as fetched
          if (i_mem_rdata == `FDC_HALT_OP)
            st_next = FDC_HALTED;
          else if (i_mem_rdata != `FDC_HCALL_OP)
            st_next = FDC_DISPATCH;
        end else if (idx_reg == 3'h1) begin
          eblk_next[31:16] = i_mem_rdata;
        end else begin
          eblk_next[15:0] = i_mem_rdata;
          st_next = FDC_RD_ECB;
        end
      end
      FDC_RD_ECB: if (i_mem_ack) begin
        dum_next = (i_mem_rdata != 16'h0000);
        st_next = FDC_DISPATCH;
      end
      FDC_DISPATCH: begin
        pcl_next = 1'b1;
        pc_next = ent_addr;
        blk_next = (ent_addr[`FDC_RING_MSB:`FDC_RING_LSB]
                    == 2'h0);
        st_next = FDC_IDLE;
      end
      FDC_HALTED: if (resume_reg)
        st_next = FDC_IDLE;
      FDC_POP_FLAG: if (i_mem_ack)
        st_next = FDC_POP_NEXT;
      FDC_POP_NEXT: if (i_mem_ack) begin
        nxt_next = back(nxt_reg, first_reg, last_reg);
        if (depth_reg != 4'h0)
          depth_next = depth_reg - 4'h1;
        st_next = FDC_IDLE;
      end
      default: st_next = FDC_IDLE;
    endcase
    // Memory request for the state being entered
    req_next = 1'b1;
    we_next = 1'b0;
    addr_next = o_mem_addr;
    wd_next = o_mem_wdata;
    case (st_next)
      FDC_RD_PTR:
        addr_next = cblk_reg + {24'h00_0000, `FDC_CS_FIRST}
                    + {29'h0000_0000, idx_next};
      FDC_WR_FRAME: begin
        we_next = 1'b1;
        addr_next = cblk_reg + {16'h0000, nxt_next}
                    + {29'h0000_0000, idx_next};
        wd_next = frame_word(f_next, idx_next);
      end
      FDC_WR_NEXT: begin
        we_next = 1'b1;
        addr_next = cblk_reg + {24'h00_0000, `FDC_CS_NEXT};
        wd_next = adv(nxt_next, first_next, last_next);
      end
      FDC_RD_VEC:
        addr_next = cblk_reg + {24'h00_0000, vec_loc(f_next.dest)}
                    + {29'h0000_0000, idx_next};
      // Vector low half lands this edge, so use its next value
      FDC_RD_ENT:
        addr_next = {vec_next[31:16],
                     vec_next[15:0] + type_off(f_next.num)}
                    + {29'h0000_0000, idx_next};
      FDC_RD_ECB:
        addr_next = eblk_next + `FDC_ENT_NARGS;
      FDC_POP_FLAG: begin
        we_next = 1'b1;
        addr_next = flag_next;
        wd_next = 16'h0001;
      end
      FDC_POP_NEXT: begin
        we_next = 1'b1;
        addr_next = cblk_reg + {24'h00_0000, `FDC_CS_NEXT};
        wd_next = back(nxt_next, first_next, last_next);
      end
      default: req_next = 1'b0;
    endcase
    rdy_next = (st_next == FDC_IDLE);
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      st_reg <= FDC_IDLE;
      idx_reg <= 3'h0;
      f_reg <= '0;
      first_reg <= 16'h0000;
      nxt_reg <= 16'h0000;
      last_reg <= 16'h0000;
      vec_reg <= 32'h0000_0000;
      eblk_reg <= 32'h0000_0000;
      flag_reg <= 32'h0000_0000;
      depth_reg <= 4'h0;
      lost_reg <= 8'h00;
      o_dummy_args <= 1'b0;
      o_pc <= 32'h0000_0000;
      o_pc_load <= 1'b0;
      o_int_block <= 1'b0;
      o_mode64v <= 1'b0;
      o_halt <= 1'b0;
      o_ready <= 1'b0;
      o_mem_req <= 1'b0;
      o_mem_we <= 1'b0;
      o_mem_addr <= 32'h0000_0000;
      o_mem_wdata <= 16'h0000;
    end else begin
      st_reg <= st_next;
      idx_reg <= idx_next;
      f_reg <= f_next;
      first_reg <= first_next;
      nxt_reg <= nxt_next;
      last_reg <= last_next;
      vec_reg <= vec_next;
      eblk_reg <= eblk_next;
      flag_reg <= flag_next;
      depth_reg <= depth_next;
      lost_reg <= lost_next;
      o_dummy_args <= dum_next;
      o_pc <= pc_next;
      o_pc_load <= pcl_next;
      o_int_block <= blk_next;
      o_mode64v <= m64_next;
      o_halt <= (st_next == FDC_HALTED);
      o_ready <= rdy_next;
      o_mem_req <= req_next;
      o_mem_we <= we_next;
      o_mem_addr <= addr_next;
      o_mem_wdata <= wd_next;
    end
  end

  // ****************************************
  // AXI4-Lite register slave
  // ****************************************
  logic        aw_have, w_have, do_wr, do_rd;
  logic [7:0]  awa_reg;
  logic [31:0] wd_reg;
  logic        en_n, res_n, awh_n, wh_n;
  logic [31:0] cblk_n, rdat_n;
  logic [1:0]  rresp_n;

  assign do_wr = aw_have && w_have && !o_bvalid;
  assign do_rd = i_arvalid && o_arready;

  always_comb begin
    en_n = en_reg;
    cblk_n = cblk_reg;
    res_n = 1'b0;
    awh_n = (aw_have || (i_awvalid && o_awready)) && !do_wr;
    wh_n = (w_have || (i_wvalid && o_wready)) && !do_wr;
    if (do_wr) begin
      if (awa_reg == `FDC_REG_CTRL && i_wstrb[0] == 1'b1) begin
        en_n = wd_reg[`FDC_CTRL_EN];
        res_n = wd_reg[`FDC_CTRL_RESUME];
      end else if (awa_reg == `FDC_REG_CBLK) begin
        cblk_n = wd_reg;
      end
    end
    rresp_n = `FDC_RESP_OKAY;
    case (i_araddr)
      `FDC_REG_CTRL:   rdat_n = {31'h0000_0000, en_reg};
      `FDC_REG_CBLK:   rdat_n = cblk_reg;
      `FDC_REG_STATUS: rdat_n = {8'h00, lost_reg, 4'h0, depth_reg,
                                 5'h00, o_mode64v, o_halt, !o_ready};
      `FDC_REG_PC:     rdat_n = o_pc;
      `FDC_REG_ENTRY:  rdat_n = eblk_reg;
      default: begin
        rdat_n = 32'h0000_0000;
        rresp_n = `FDC_RESP_SLV;
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      en_reg <= 1'b0;
      cblk_reg <= 32'h0000_0000;
      resume_reg <= 1'b0;
      aw_have <= 1'b0;
      w_have <= 1'b0;
      awa_reg <= 8'h00;
      wd_reg <= 32'h0000_0000;
      o_awready <= 1'b0;
      o_wready <= 1'b0;
      o_bvalid <= 1'b0;
      o_bresp <= `FDC_RESP_OKAY;
      o_arready <= 1'b0;
      o_rvalid <= 1'b0;
      o_rdata <= 32'h0000_0000;
      o_rresp <= `FDC_RESP_OKAY;
    end else begin
      en_reg <= en_n;
      cblk_reg <= cblk_n;
      resume_reg <= res_n;
      aw_have <= awh_n;
      w_have <= wh_n;
      if (i_awvalid && o_awready)
        awa_reg <= {i_awaddr[7:2], 2'h0};
      if (i_wvalid && o_wready)
        wd_reg <= i_wdata;
      o_awready <= !awh_n && !(i_awvalid && o_awready);
      o_wready <= !wh_n && !(i_wvalid && o_wready);
      if (do_wr) begin
        o_bvalid <= 1'b1;
        o_bresp <= (awa_reg == `FDC_REG_CTRL || awa_reg == `FDC_REG_CBLK)
                   ? `FDC_RESP_OKAY : `FDC_RESP_SLV;
      end else if (i_bready) begin
        o_bvalid <= 1'b0;
      end
      o_arready <= !o_rvalid && !do_rd;
      if (do_rd) begin
        o_rvalid <= 1'b1;
        o_rdata <= rdat_n;
        o_rresp <= rresp_n;
      end else if (i_rready) begin
        o_rvalid <= 1'b0;
      end
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  sequence s_take;
    st_reg == FDC_IDLE && i_fault_valid && en_reg;
  endsequence
  property p_save_first;
    @(posedge i_clk) disable iff (i_reset)
      s_take |=> st_reg == FDC_RD_PTR ##0 o_mem_req && !o_mem_we;
  endproperty
  a_save_first: assert property (p_save_first)
    else $error("fault not saved first");
  property p_halt;
    @(posedge i_clk) disable iff (i_reset)
      st_reg == FDC_RD_ENT && idx_reg == 3'h0 && i_mem_ack
      && i_mem_rdata == `FDC_HALT_OP |=> o_halt [*2];
  endproperty
  a_halt: assert property (p_halt)
    else $error("halt entry did not stop");
  property p_block;
    @(posedge i_clk) disable iff (i_reset)
      o_pc_load |-> o_int_block
        == (o_pc[`FDC_RING_MSB:`FDC_RING_LSB] == 2'h0);
  endproperty
  a_block: assert property (p_block)
    else $error("interrupt block wrong");
  property p_pc_ring;
    @(posedge i_clk) disable iff (i_reset)
      o_pc_load |-> o_pc[31:16] == vec_reg[31:16];
  endproperty
  a_pc_ring: assert property (p_pc_ring)
    else $error("pc ring not from vector");
  property p_vec_loc;
    @(posedge i_clk) disable iff (i_reset)
      st_reg == FDC_RD_VEC && idx_reg == 3'h0 |-> o_mem_addr
        == cblk_reg + {24'h00_0000, vec_loc(f_reg.dest)};
  endproperty
  a_vec_loc: assert property (p_vec_loc)
    else $error("wrong vector word");
  property p_code;
    @(posedge i_clk) disable iff (i_reset)
      st_reg == FDC_WR_FRAME && idx_reg == 3'h3
        |-> o_mem_we && o_mem_wdata == code_of(f_reg);
  endproperty
  a_code: assert property (p_code)
    else $error("fault code not in word 3");
  property p_wrap;
    @(posedge i_clk) disable iff (i_reset)
      st_reg == FDC_WR_NEXT && i_mem_ack |=> nxt_reg <= last_reg
        || nxt_reg == first_reg;
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("next pointer ran past last");
  property p_mode;
    @(posedge i_clk) disable iff (i_reset)
      st_reg == FDC_WR_NEXT && i_mem_ack |=> o_mode64v
        && st_reg == FDC_RD_VEC;
  endproperty
  a_mode: assert property (p_mode)
    else $error("64V not set after advance");
  property p_flag;
    @(posedge i_clk) disable iff (i_reset)
      st_reg == FDC_POP_FLAG |-> o_mem_we && o_mem_wdata == 16'h0001;
  endproperty
  a_flag: assert property (p_flag)
    else $error("flag word not one");
  property p_entry;
    @(posedge i_clk) disable iff (i_reset)
      st_reg == FDC_RD_ENT && idx_reg == 3'h0
        |-> o_mem_addr[15:0] == vec_reg[15:0] + type_off(f_reg.num);
  endproperty
  a_entry: assert property (p_entry)
    else $error("entry address wrong");
endmodule

//--- fdc_mem_model.sv
// Word memory holding control block and fault tables for the dispatch unit
`timescale 1ns/1ns
module fdc_mem_model (
  input  wire logic        i_clk,
  input  wire logic        i_slow,
  input  wire logic        i_req,
  input  wire logic        i_we,
  input  wire logic [31:0] i_addr,
  input  wire logic [15:0] i_wdata,
  output logic             o_ack,
  output logic [15:0]      o_rdata
);
  logic [15:0] mem [0:1023];
  logic [1:0]  wait_reg;
  initial begin
    o_ack = 1'b0;
    o_rdata = 16'h0000;
    wait_reg = 2'h0;
  end
  // One ack per address; slow mode stalls two cycles first
  always @(posedge i_clk) begin
    o_ack <= 1'b0;
    // Released data lines toggle so stale words never look valid
    o_rdata <= ~o_rdata;
    if (i_req && !o_ack) begin
      if (i_slow && wait_reg != 2'h2) begin
        wait_reg <= wait_reg + 2'h1;
      end else begin
        wait_reg <= 2'h0;
        o_ack <= 1'b1;
        if (i_we) begin
          mem[i_addr[9:0]] <= i_wdata;
        end else begin
          o_rdata <= mem[i_addr[9:0]];
        end
      end
    end
  end
endmodule

//--- tb_top.sv
// Self-checking bench for the fault dispatch unit
`timescale 1ns/1ns
`include "fdc_defines.svh"
module tb_top
  import fdc_pkg::*;
();
  localparam logic [9:0]  CB_BASE = 10'h100;
  localparam logic [15:0] FIRST = 16'h003F;
  localparam logic [15:0] LAST = 16'h005D;
  localparam logic [3:0]  NUMS [12] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5,
                                        4'h8, 4'h9, 4'hA, 4'hB, 4'hC, 4'hD};
  localparam logic [31:0] VECS [4] = '{32'h0000_0200, 32'h2000_0240,
                                       32'h6000_0280, 32'h0000_02C0};
  localparam logic [7:0]  VLOC [4] = '{`FDC_VEC_RING0, `FDC_VEC_RING1,
                                       `FDC_VEC_RING3, `FDC_VEC_PAGE};
  logic        i_clk, i_reset, fault_valid, pop_valid, slow;
  fdc_fault_s  fault_in;
  logic [31:0] pop_addr, mem_addr, o_pc, wdata, rdata;
  logic        mem_req, mem_we, mem_ack;
  logic [15:0] mem_wdata, mem_rdata;
  logic        o_ready, o_pc_load, o_int_block, o_dummy, o_m64, o_halt;
  logic [7:0]  awaddr, araddr;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [1:0]  bresp, rresp;
  int          num_errors, checks;

  fdc_dispatch uut (
    .i_clk(i_clk), .i_reset(i_reset), .i_fault_valid(fault_valid),
    .i_fault(fault_in), .i_pop_valid(pop_valid), .i_pop_flag_addr(pop_addr),
    .o_ready(o_ready), .o_mem_req(mem_req), .o_mem_we(mem_we),
    .o_mem_addr(mem_addr), .o_mem_wdata(mem_wdata), .i_mem_ack(mem_ack),
    .i_mem_rdata(mem_rdata), .o_pc_load(o_pc_load), .o_pc(o_pc),
    .o_int_block(o_int_block), .o_dummy_args(o_dummy), .o_mode64v(o_m64),
    .o_halt(o_halt), .i_awaddr(awaddr), .i_awvalid(awvalid),
    .o_awready(awready), .i_wdata(wdata), .i_wstrb(4'hF),
    .i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp),
    .o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr),
    .i_arvalid(arvalid), .o_arready(arready), .o_rdata(rdata),
    .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready));
  fdc_mem_model mm (
    .i_clk(i_clk), .i_slow(slow), .i_req(mem_req), .i_we(mem_we),
    .i_addr(mem_addr), .i_wdata(mem_wdata), .o_ack(mem_ack),
    .o_rdata(mem_rdata));

  // ******************************
  // Tasks
  // ******************************
  function automatic logic [9:0] pw(input logic [15:0] off);
    return 10'(CB_BASE + off);
  endfunction
  function automatic logic [15:0] exp_code(input fdc_fault_s f);
    case (f.num)
      `FDC_NUM_SEMA: return {15'h0000, f.sub[0]};
      `FDC_NUM_SEG: return f.sub[0] ? 16'h0002 : 16'h0001;
      `FDC_NUM_PTR: return f.sub[0] ? `FDC_CODE_CALL : f.code;
      default: return f.code;
    endcase
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("checks=%0d errors=%0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v,
                        output logic [1:0] r);
    @(posedge i_clk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge i_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] v,
                        output logic [1:0] r);
    @(posedge i_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge i_clk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    v = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  task automatic fault(input logic [3:0] n, input logic s, input int d);
    fdc_fault_s  f;
    logic [15:0] nx, ex;
    logic [15:0] w [6];
    f = '{n, {1'b0, s}, fdc_dest_e'(2'(d)), 16'h1200 + 16'(n),
          32'h0001_0000 + 32'(n), 16'h0C00 + 16'(n), 32'h0002_0400 + 32'(n)};
    nx = mm.mem[pw(`FDC_CS_NEXT)];
    ex = (nx + 16'h0006 > LAST) ? FIRST : nx + 16'h0006;
    w = '{f.pc[31:16], f.pc[15:0], f.keys, exp_code(f),
          f.addr[31:16], f.addr[15:0]};
    @(posedge i_clk);
    fault_in <= f;
    fault_valid <= 1'b1;
    do @(posedge i_clk); while (!o_ready);
    fault_valid <= 1'b0;
    do @(posedge i_clk); while (!o_pc_load && !o_halt);
    for (int k = 0; k < 6; k++) begin
      check(mm.mem[pw(nx + 16'(k))], w[k]);
    end
    check(mm.mem[pw(`FDC_CS_NEXT)], ex);
    check(o_m64, 1'b1);
    if (o_pc_load) begin
      check(o_pc, VECS[d] + 32'({n, 2'b00}));
      check(o_int_block, VECS[d][30:29] == 2'h0);
    end
  endtask
  task automatic pop();
    logic [15:0] nx;
    nx = mm.mem[pw(`FDC_CS_NEXT)];
    mm.mem[10'h300] = 16'h0000;
    @(posedge i_clk);
    pop_valid <= 1'b1;
    do @(posedge i_clk); while (!o_ready);
    pop_valid <= 1'b0;
    repeat (2) @(posedge i_clk);
    while (!o_ready) @(posedge i_clk);
    check(mm.mem[10'h300], 32'h0000_0001);
    check(mm.mem[pw(`FDC_CS_NEXT)], (nx == FIRST) ? LAST : nx - 16'h0006);
  endtask

  // ******************************
  // Tests
  // ******************************
  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end
  // Generous cap of 20,000 cycles: planned run is little over a thousand cycles
  initial begin
    #1_000_000;
    num_errors++;
    close_out();
  end
  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    num_errors = 0;
    checks = 0;
    i_reset = 1'b1;
    {fault_valid, pop_valid, slow, fault_in} = '0;
    pop_addr = 32'h0000_0300;
    {awaddr, awvalid, wdata, wvalid, bready} = '0;
    {araddr, arvalid, rready} = '0;
    for (int k = 0; k < 1024; k++) mm.mem[k] = 16'hFFFF;
    for (int k = 0; k < 4; k++) begin
      mm.mem[pw(VLOC[k])] = VECS[k][31:16];
      mm.mem[pw(VLOC[k]) + 10'h001] = VECS[k][15:0];
    end
    mm.mem[pw(`FDC_CS_FIRST)] = FIRST;
    mm.mem[pw(`FDC_CS_NEXT)] = FIRST;
    mm.mem[pw(`FDC_CS_LAST)] = LAST;
    mm.mem[10'h24C] = `FDC_HCALL_OP;
    mm.mem[10'h24D] = 16'h0000;
    mm.mem[10'h24E] = 16'h0320;
    mm.mem[10'h324] = 16'h0002;
    mm.mem[10'h250] = `FDC_HCALL_OP;
    mm.mem[10'h251] = 16'h0000;
    mm.mem[10'h252] = 16'h0330;
    mm.mem[10'h334] = 16'h0000;
    mm.mem[10'h208] = `FDC_HALT_OP;
    repeat (2) @(posedge i_clk);
    i_reset <= 1'b0;
    repeat (2) @(posedge i_clk);
    axi_rd(8'h40, d, r);
    check(r, `FDC_RESP_SLV);
    check(d, 32'h0000_0000);
    axi_wr(8'h44, 32'h0000_0001, r);
    check(r, `FDC_RESP_SLV);
    axi_wr(`FDC_REG_CBLK, 32'(CB_BASE), r);
    check(r, `FDC_RESP_OKAY);
    axi_rd(`FDC_REG_CBLK, d, r);
    check(d, 32'(CB_BASE));
    // Disabled unit must leave a pending fault untouched
    @(posedge i_clk);
    fault_valid <= 1'b1;
    repeat (6) @(posedge i_clk) check(mem_req, 1'b0);
    fault_valid <= 1'b0;
    axi_wr(`FDC_REG_CTRL, 32'h0000_0001, r);
    $display("test setup done");
    for (int i = 0; i < 12; i++) begin
      fault(NUMS[i], 1'b1, i % 4);
      pop();
    end
    $display("test fault types done");
    fault(4'h3, 1'b0, 1);
    check(o_dummy, 1'b1);
    axi_rd(`FDC_REG_ENTRY, d, r);
    check(d, 32'h0000_0320);
    pop();
    fault(4'h4, 1'b0, 1);
    check(o_dummy, 1'b0);
    pop();
    $display("test handler call done");
    repeat (2) begin
      fault(4'h2, 1'b0, 0);
      check(o_halt, 1'b1);
      axi_wr(`FDC_REG_CTRL, 32'h0000_0003, r);
      repeat (2) @(posedge i_clk);
      check(o_halt, 1'b0);
      pop();
    end
    $display("test halt done");
    slow <= 1'b1;
    for (int i = 0; i < 7; i++) fault(i[0] ? 4'hC : 4'h5, 1'b0, 2);
    axi_rd(`FDC_REG_STATUS, d, r);
    check(d, 32'h0001_0604);
    axi_rd(`FDC_REG_PC, d, r);
    check(d, 32'h6000_0294);
    $display("test wrap done");
    close_out();
  end
endmodule
